// [rtl/pit_cfg.svh]
`ifndef PIT_CFG_SVH
`define PIT_CFG_SVH
`define PIT_A_CTRL       4'h0
`define PIT_A_INTERVAL   4'h1
`define PIT_A_COUNT      4'h2
`define PIT_A_STATUS     4'h3
`define PIT_A_IRQ_STAT   4'h4
`define PIT_A_IRQ_MASK   4'h5
`define PIT_A_PW_ENTRY   4'h6
`define PIT_A_PW_NEW     4'h7
`define PIT_A_SER_UP     4'h8
`define PIT_A_SER_LO     4'h9
`define PIT_A_SETPOINT   4'ha
`define PIT_F_MODE_LSB   0
`define PIT_F_BASE       3
`define PIT_F_END_ACT    4
`define PIT_F_DISP_EN    5
`define PIT_F_RUN        6
`define PIT_CTRL_RST     16'h0040
`define PIT_PW_RST       16'h1111
`define PIT_CLK_HZ       100000000
`define PIT_SEC_CYC      (`PIT_CLK_HZ)
`define PIT_MIN_S        60
`define PIT_LOCK_MIN     10
// Widened first: the 32-bit product would overflow
`define PIT_LOCK_CYC     (36'(`PIT_LOCK_MIN) * 36'(`PIT_MIN_S) * 36'(`PIT_CLK_HZ))
`define PIT_MAX_FAIL     3'h5
`endif

// [rtl/pit_pkg.sv]
package pit_pkg;
  typedef enum logic [2:0] {
    pit_mode_off   = 3'b000,
    pit_mode_sp    = 3'b001,
    pit_mode_key   = 3'b010,
    pit_mode_run   = 3'b011,
    pit_mode_kss   = 3'b100
  } pit_mode_type;
  typedef enum logic [1:0] {
    pit_st_idle    = 2'b00,
    pit_st_count   = 2'b01,
    pit_st_stopped = 2'b10,
    pit_st_done    = 2'b11
  } pit_state_type;
endpackage

// [rtl/pit_tick.sv]
`include "pit_cfg.svh"
module pit_tick #(
  parameter logic [31:0] SEC_CYC = `PIT_SEC_CYC
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic clr,
  input  wire logic minutes,
  output logic      tick
);
  logic [31:0] cyc_q;
  logic [5:0]  sec_q;
  wire         sec_end = (cyc_q == SEC_CYC - 32'h1);
  wire         min_end = (sec_q == 6'(`PIT_MIN_S - 1));
  // One unit per second or per minute [R6] [R7]
  assign tick = ce & sec_end & (~minutes | min_end);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cyc_q <= 32'h0;
      sec_q <= 6'h0;
    end else if (ce) begin
      cyc_q <= (clr | sec_end) ? 32'h0 : cyc_q + 32'h1;
      if (clr) sec_q <= 6'h0;
      else if (sec_end) sec_q <= min_end ? 6'h0 : sec_q + 6'h1;
    end
  end
endmodule // pit_tick

// [rtl/pit_pw.sv]
`include "pit_cfg.svh"
module pit_pw #(
  parameter logic [35:0] LOCK_CYC = 36'(`PIT_LOCK_CYC)
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        try_v,
  input  wire logic [15:0] try_val,
  input  wire logic        new_v,
  input  wire logic [15:0] new_val,
  output logic             unlocked,
  output logic             blocked,
  output logic             fail_ev
);
  logic [15:0] pw_q;
  logic [2:0]  fails_q;
  logic [35:0] lock_q;
  logic        unl_q;
  wire         good = try_val == pw_q;
  wire         take = try_v & ~blocked;
  assign blocked  = lock_q != 36'h0;
  assign unlocked = unl_q;
  assign fail_ev  = ce & take & ~good;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pw_q    <= `PIT_PW_RST;
      fails_q <= 3'h0;
      lock_q  <= 36'h0;
      unl_q   <= 1'b0;
    end else if (ce) begin
      if (new_v && unl_q && new_val != 16'h0) pw_q <= new_val; // [R12]
      if (blocked) lock_q <= lock_q - 36'h1; // [R15]
      if (take) begin
        unl_q <= good;
        if (good) fails_q <= 3'h0;
        else if (fails_q == `PIT_MAX_FAIL - 3'h1) begin
          fails_q <= 3'h0;
          lock_q  <= LOCK_CYC; // [R15]
        end else fails_q <= fails_q + 3'h1;
      end
    end
  end
endmodule // pit_pw

// [rtl/pit_top.sv]
// Function
// [R1] Mode off: timer idle, no control effect
// [R2] Setpoint mode: start when value reaches setpoint
// [R3] Key mode: press starts, later press restarts
// [R4] Run mode: start when control becomes enabled
// [R5] Start-stop mode: start, stop, restart cycle
// [R6] Interval counted in seconds or minutes
// [R7] One time base shared by all intervals
// [R8] End action none: run unchanged
// [R9] End action disable: clear run at expiry
// [R10] Display option shows or hides interval
// [R11] Mode off hides other timer settings
// [R12] New password zero keeps old password
// [R13] Serial number read as two halves
// [R14] Password entry precedes protected levels
// [R15] Five wrong passwords block ten minutes
// [R16] Key press taken once per edge
// [R17] Count per tick, one-cycle expiry pulse
`include "pit_cfg.svh"
module pit_top #(
  parameter logic [31:0] SEC_CYC    = `PIT_SEC_CYC,
  parameter logic [35:0] LOCK_CYC   = 36'(`PIT_LOCK_CYC),
  parameter logic [15:0] SERIAL_UP  = 16'h1234, // Arbitrary value
  parameter logic [15:0] SERIAL_LO  = 16'h5678  // Arbitrary value
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic [15:0] process_value,
  input  wire logic        func_key,
  output logic             control_run,
  output logic             timer_expired,
  output logic             interval_visible,
  output logic             irq
);
  logic [15:0]           ctrl_q;
  logic [15:0]           timer_interval_q;
  logic [15:0]           setpoint_value_q;
  logic [15:0]           count_q;
  logic [15:0]           rdata_q;
  logic [2:0]            ist_q;
  logic [2:0]            imask_q;
  logic                  key_q;
  logic                  reached_q;
  logic                  run_prev_q;
  logic                  exp_q;
  pit_pkg::pit_state_type st_q;
  pit_pkg::pit_state_type st_d;

  wire pit_pkg::pit_mode_type mode = pit_pkg::pit_mode_type'(ctrl_q[`PIT_F_MODE_LSB +: 3]);
  wire        minutes  = ctrl_q[`PIT_F_BASE];
  wire        end_dis  = ctrl_q[`PIT_F_END_ACT];
  wire        run      = ctrl_q[`PIT_F_RUN];
  wire        timer_on = (mode != pit_pkg::pit_mode_off); // [R1]
  wire        wr_ctrl  = wr & (addr == `PIT_A_CTRL);
  wire        wr_intv  = wr & (addr == `PIT_A_INTERVAL) & timer_on; // [R11]
  wire        wr_imask = wr & (addr == `PIT_A_IRQ_MASK);
  wire        wr_sp    = wr & (addr == `PIT_A_SETPOINT);
  wire        rd_ist   = rd & (addr == `PIT_A_IRQ_STAT);
  wire        key_ev   = func_key & ~key_q; // [R16]
  wire        reached  = process_value >= setpoint_value_q;
  wire        sp_ev    = reached & ~reached_q; // [R2]
  wire        run_ev   = run & ~run_prev_q; // [R4]
  wire        tick;
  wire        expire   = (st_q == pit_pkg::pit_st_count) & tick &
                         (count_q + 16'h1 >= timer_interval_q); // [R17]
  wire        unlocked;
  wire        blocked;
  wire        fail_ev;
  wire        restart;

  pit_tick #(.SEC_CYC(SEC_CYC)) u_tick (
    .mclk    (mclk),
    .rst     (rst),
    .ce      (ce),
    .clr     (restart),
    .minutes (minutes), // [R7]
    .tick    (tick)
  );

  // Password entry gates protected writes [R14]
  pit_pw #(.LOCK_CYC(LOCK_CYC)) u_pw (
    .mclk     (mclk),
    .rst      (rst),
    .ce       (ce),
    .try_v    (wr & (addr == `PIT_A_PW_ENTRY)),
    .try_val  (wdata),
    .new_v    (wr & (addr == `PIT_A_PW_NEW)),
    .new_val  (wdata),
    .unlocked (unlocked),
    .blocked  (blocked),
    .fail_ev  (fail_ev)
  );

  // Trigger selection per mode
  always_comb begin
    st_d = st_q;
    unique case (mode)
      pit_pkg::pit_mode_sp:  if (sp_ev) st_d = pit_pkg::pit_st_count; // [R2]
      pit_pkg::pit_mode_key: if (key_ev) st_d = pit_pkg::pit_st_count; // [R3]
      pit_pkg::pit_mode_run: if (run_ev) st_d = pit_pkg::pit_st_count; // [R4]
      pit_pkg::pit_mode_kss: if (key_ev) begin // [R5]
        unique case (st_q)
          pit_pkg::pit_st_count:   st_d = pit_pkg::pit_st_stopped;
          pit_pkg::pit_st_stopped: st_d = pit_pkg::pit_st_count;
          pit_pkg::pit_st_idle,
          pit_pkg::pit_st_done:    st_d = pit_pkg::pit_st_count;
        endcase
      end
      default:               st_d = pit_pkg::pit_st_idle; // [R1]
    endcase
    if (expire && st_d == pit_pkg::pit_st_count && st_q == pit_pkg::pit_st_count)
      st_d = pit_pkg::pit_st_done;
  end

  // Restart clears count; a stopped-to-count resume also restarts [R5]
  assign restart = (st_d == pit_pkg::pit_st_count) &&
                   (key_ev | sp_ev | run_ev) && timer_on &&
                   !(mode == pit_pkg::pit_mode_kss && st_q == pit_pkg::pit_st_count);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q       <= pit_pkg::pit_st_idle;
      count_q    <= 16'h0;
      key_q      <= 1'b0;
      reached_q  <= 1'b0;
      run_prev_q <= 1'b0;
      exp_q      <= 1'b0;
    end else if (ce) begin
      st_q       <= st_d;
      key_q      <= func_key; // [R16]
      reached_q  <= reached;
      run_prev_q <= run;
      exp_q      <= expire; // [R17]
      if (restart) count_q <= 16'h0; // [R3]
      else if (st_q == pit_pkg::pit_st_count && tick) count_q <= count_q + 16'h1; // [R6]
    end
  end

  // Control register; expiry may drop run, and that clear wins over a same-cycle control write
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q           <= `PIT_CTRL_RST;
      timer_interval_q <= 16'h0;
      setpoint_value_q <= 16'h0;
      imask_q          <= 3'h0;
    end else if (ce) begin
      if (wr_ctrl && unlocked) ctrl_q <= {9'h0, wdata[6:0]}; // [R14]
      if (expire && end_dis && timer_on) ctrl_q[`PIT_F_RUN] <= 1'b0; // [R9]
      if (wr_intv && unlocked) timer_interval_q <= wdata;
      if (wr_sp) setpoint_value_q <= wdata;
      if (wr_imask) imask_q <= wdata[2:0];
    end
  end

  // Sticky events: expiry, password fail, lockout; set wins over read clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) ist_q <= 3'h0;
    else if (ce) ist_q <= (rd_ist ? 3'h0 : ist_q) | {blocked, fail_ev, expire};
  end

  // Hidden items read zero [R10] [R11]
  wire [15:0] intv_view = (timer_on && ctrl_q[`PIT_F_DISP_EN]) ? timer_interval_q : 16'h0;
  wire [15:0] rd_mux =
    (addr == `PIT_A_CTRL)     ? ctrl_q :
    (addr == `PIT_A_INTERVAL) ? intv_view :
    (addr == `PIT_A_COUNT)    ? (timer_on ? count_q : 16'h0) :
    (addr == `PIT_A_STATUS)   ? {11'h0, blocked, unlocked, exp_q, st_q} :
    (addr == `PIT_A_IRQ_STAT) ? {13'h0, ist_q} :
    (addr == `PIT_A_IRQ_MASK) ? {13'h0, imask_q} :
    (addr == `PIT_A_SER_UP)   ? SERIAL_UP : // [R13]
    (addr == `PIT_A_SER_LO)   ? SERIAL_LO : // [R13]
    (addr == `PIT_A_SETPOINT) ? setpoint_value_q : 16'h0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) rdata_q <= 16'h0;
    else if (ce && rd) rdata_q <= rd_mux;
  end

  assign rdata            = rdata_q;
  assign control_run      = run; // [R8]
  assign timer_expired    = exp_q;
  assign interval_visible = timer_on & ctrl_q[`PIT_F_DISP_EN]; // [R10]
  assign irq              = |(ist_q & imask_q);

  chk_expiry_pulse: assert property (@(posedge mclk) disable iff (rst)
    exp_q |=> !exp_q) else $error("expiry longer than one cycle"); // [R17]
  chk_off_idle: assert property (@(posedge mclk) disable iff (rst)
    ce && !timer_on |=> st_q == pit_pkg::pit_st_idle) else $error("timer runs while off"); // [R1]
  chk_end_disable: assert property (@(posedge mclk) disable iff (rst)
    ce && expire && end_dis && timer_on |=> !control_run) else $error("run kept"); // [R9]
  chk_end_keep: assert property (@(posedge mclk) disable iff (rst)
    ce && expire && !end_dis && !wr_ctrl |=> control_run == $past(run)) else $error("run changed"); // [R8]
  chk_key_edge: assert property (@(posedge mclk) disable iff (rst)
    ce && mode == pit_pkg::pit_mode_key && key_ev |=> st_q == pit_pkg::pit_st_count && count_q == 16'h0) else $error("key no restart"); // [R3]
  chk_kss_stop: assert property (@(posedge mclk) disable iff (rst)
    ce && mode == pit_pkg::pit_mode_kss && key_ev && st_q == pit_pkg::pit_st_count
    |=> st_q == pit_pkg::pit_st_stopped) else $error("no stop"); // [R5]
  chk_sp_start: assert property (@(posedge mclk) disable iff (rst)
    ce && mode == pit_pkg::pit_mode_sp && sp_ev |=> st_q == pit_pkg::pit_st_count) else $error("sp no start"); // [R2]
  chk_run_start: assert property (@(posedge mclk) disable iff (rst)
    ce && mode == pit_pkg::pit_mode_run && run_ev |=> st_q == pit_pkg::pit_st_count) else $error("run no start"); // [R4]
  chk_hidden_zero: assert property (@(posedge mclk) disable iff (rst)
    ce && rd && addr == `PIT_A_INTERVAL && !interval_visible |=> rdata == 16'h0) else $error("hidden read"); // [R10]
  cov_expire: cover property (@(posedge mclk) disable iff (rst) exp_q);
  cov_kss_resume: cover property (@(posedge mclk) disable iff (rst)
    st_q == pit_pkg::pit_st_stopped ##1 st_q == pit_pkg::pit_st_count);
  cov_lock: cover property (@(posedge mclk) disable iff (rst) $rose(blocked));
endmodule // pit_top

// [bench/pit_panel.sv]
module pit_panel (
  input  wire logic  mclk,
  output logic       func_key,
  output logic [15:0] process_value
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    func_key = 1'b0;
    process_value = 16'h0000;
  end
  // Held for four cycles so that a level-sensitive key would act four times
  task automatic press();
    @(posedge mclk) func_key <= 1'b1;
    repeat (4) @(posedge mclk);
    func_key <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic set_pv(input logic [15:0] v);
    @(posedge mclk) process_value <= v;
  endtask
endmodule // pit_panel

// [bench/tb_process_interval_timer.sv]
module tb_process_interval_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic [15:0] process_value;
  logic        func_key;
  logic        control_run;
  logic        timer_expired;
  logic        interval_visible;
  logic        irq;
  logic [15:0] v;
  int          err_total = 0;
  int          num_checks = 0;
  always #5 mclk = ~mclk;
  // Short counts keep the run brief
  pit_top #(.SEC_CYC(32'd10), .LOCK_CYC(36'd50),
    .SERIAL_UP(16'hab01), .SERIAL_LO(16'hcd02)) i_dut ( // Arbitrary serial value
    .mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .process_value(process_value), .func_key(func_key),
    .control_run(control_run), .timer_expired(timer_expired),
    .interval_visible(interval_visible), .irq(irq));
  pit_panel i_panel (.mclk(mclk), .func_key(func_key), .process_value(process_value));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Bounded wait for expiry, then the pulse must be gone
  task automatic wait_exp();
    for (int i = 0; i < 300; i++) begin
      @(posedge mclk);
      #1;
      if (timer_expired === 1'b1) break;
    end
    check("expired", timer_expired, 16'h0001);
    if (timer_expired !== 1'b1) tally_and_finish();
    @(posedge mclk);
    #1 check("expired pulse", timer_expired, 16'h0000);
  endtask
  task automatic state_is(input logic [1:0] s);
    rd_reg(4'h3, v);
    check("state", v[1:0], s);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(4'h8, v); check("serial up", v, 16'hab01);
    rd_reg(4'h9, v); check("serial lo", v, 16'hcd02);
    rd_reg(4'h0, v); check("ctrl reset", v, 16'h0040);
    check("run reset", control_run, 16'h0001);
    rd_reg(4'hf, v); check("unmapped", v, 16'h0000);
    for (int i = 0; i < 5; i++) wr_reg(4'h6, 16'h0002);
    rd_reg(4'h3, v); check("blocked", v[4], 16'h0001);
    wr_reg(4'h6, 16'h1111);
    rd_reg(4'h3, v); check("refused while blocked", v[3], 16'h0000);
    repeat (60) @(posedge mclk);
    wr_reg(4'h6, 16'h1111);
    rd_reg(4'h3, v); check("unlocked", v[3], 16'h0001);
    wr_reg(4'h7, 16'h0000);
    wr_reg(4'h6, 16'h1111);
    rd_reg(4'h3, v); check("zero password ignored", v[3], 16'h0001);
    // Key mode, end action disable, display on
    wr_reg(4'h0, 16'h0072);
    wr_reg(4'h1, 16'h0003);
    wr_reg(4'h5, 16'h0001);
    #1 check("visible", interval_visible, 16'h0001);
    i_panel.press();
    state_is(2'h1);
    i_panel.press();
    state_is(2'h1);
    wait_exp();
    check("run cleared", control_run, 16'h0000);
    check("irq set", irq, 16'h0001);
    rd_reg(4'h4, v); check("irq stat", v[0], 16'h0001);
    check("irq cleared", irq, 16'h0000);
    // Off: interval frozen and hidden, key ignored
    wr_reg(4'h0, 16'h0060);
    wr_reg(4'h1, 16'h0009);
    rd_reg(4'h1, v); check("interval hidden", v, 16'h0000);
    check("hidden", interval_visible, 16'h0000);
    i_panel.press();
    state_is(2'h0);
    // Setpoint start
    wr_reg(4'ha, 16'h0064);
    wr_reg(4'h0, 16'h0061);
    rd_reg(4'h1, v); check("interval kept", v, 16'h0003);
    state_is(2'h0);
    i_panel.set_pv(16'h0064);
    repeat (2) @(posedge mclk);
    state_is(2'h1);
    // Start on control enable, end action none
    wr_reg(4'h0, 16'h0003);
    wr_reg(4'h0, 16'h0043);
    state_is(2'h1);
    wait_exp();
    check("run kept", control_run, 16'h0001);
    // Minutes base: no count after a few seconds' worth
    wr_reg(4'h0, 16'h000b);
    wr_reg(4'h0, 16'h004b);
    repeat (25) @(posedge mclk);
    rd_reg(4'h2, v); check("minute count", v, 16'h0000);
    // Start, stop, restart
    wr_reg(4'h0, 16'h0040);
    wr_reg(4'h0, 16'h0044);
    i_panel.press();
    state_is(2'h1);
    i_panel.press();
    state_is(2'h2);
    i_panel.press();
    state_is(2'h1);
    tally_and_finish();
  end
endmodule // tb_process_interval_timer
